// ---- sfb_defs.vh ----
// sfb_defs.vh: register map, field positions, reset values and timing
// assumes: included by the sensor fifo block files, no other dependency
`ifndef SFB_DEFS_VH
`define SFB_DEFS_VH

// register addresses, 7 bits
`define SFB_ADDR_PAGE_SEL      7'h01
`define SFB_ADDR_PULLUP_CTRL   7'h02
`define SFB_ADDR_WTM_LOW       7'h07
`define SFB_ADDR_WTM_HIGH_STOP 7'h08
`define SFB_ADDR_ACCEL_RATE    7'h09
`define SFB_ADDR_MODE_RATES    7'h0a
`define SFB_ADDR_BCNT_CTRL     7'h0b
`define SFB_ADDR_BCNT_TH_LOW   7'h0c
`define SFB_ADDR_IRQ1_ROUTE    7'h0d
`define SFB_ADDR_IRQ2_ROUTE    7'h0e

// reset values
`define SFB_RST_ZERO           8'h00
`define SFB_RST_PULLUP_CTRL    8'h3f

// field positions
`define SFB_BIT_EMB_PAGE       7
`define SFB_BIT_HUB_PAGE       6
`define SFB_BIT_PULLUP_EN      6
`define SFB_BIT_STOP_AT_TH     7
`define SFB_BIT_RATE_CHG_EN    4
`define SFB_BIT_WTM8           0
`define SFB_BIT_PULSED         7
`define SFB_BIT_BCNT_CLEAR     6

// writable masks, reserved bits read as zero
`define SFB_MASK_PAGE_SEL      8'hc0
`define SFB_MASK_WTM_HIGH      8'h91
`define SFB_MASK_ACCEL_RATE    8'h0f
`define SFB_MASK_MODE_RATES    8'hf7
`define SFB_MASK_BCNT_CTRL     8'h87
`define SFB_MASK_IRQ1_ROUTE    8'hfd
`define SFB_MASK_IRQ2_ROUTE    8'h7d

// fifo modes
`define SFB_MODE_BYPASS        3'b000
`define SFB_MODE_STOP_FULL     3'b001
`define SFB_MODE_CONT_TO_STOP  3'b011
`define SFB_MODE_BYP_TO_CONT   3'b100
`define SFB_MODE_CONTINUOUS    3'b110
`define SFB_MODE_BYP_TO_STOP   3'b111

// record tags
`define SFB_TAG_ACCEL          8'h01
`define SFB_TAG_TEMP           8'h02
`define SFB_TAG_TSTAMP         8'h03
`define SFB_TAG_RATE_CHG       8'h04

// data-ready pulse: time in ns, rate in MHz
`define SFB_DRDY_PULSE_NS      75000
`define SFB_CLK_MHZ            200
`define SFB_DRDY_PULSE_CYC     (`SFB_DRDY_PULSE_NS * `SFB_CLK_MHZ / 1000)

`endif

// ---- sfb_mem.v ----
// sfb_mem.v: record storage for the sensor fifo
// assumes: one clock, write and read ports driven by sfb_top
`timescale 1ns/1ps
module sfb_mem #(
  parameter WIDTH = 56,
  parameter AW    = 9
) (
  input  wire             sys_clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data_ff
);

  reg [WIDTH-1:0] store [0:(1<<AW)-1];

  // read data registered, no reset on the array itself
  always @(posedge sys_clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    rd_data_ff <= store[rd_addr];
  end

endmodule // sfb_mem

// ---- sfb_top.v ----
// sfb_top.v: sensor fifo control registers, batching, fifo, irq routing
// assumes: serial port pins are asynchronous; sample strobes are sys_clk
`timescale 1ns/1ps
`include "sfb_defs.vh"
module sfb_top #(
  parameter AW         = 9,
  parameter PULSE_CYC  = `SFB_DRDY_PULSE_CYC
) (
  input  wire          sys_clk,
  input  wire          sys_rst,
  input  wire          serial_clk,
  input  wire          serial_cs_n,
  input  wire          serial_in,
  output reg           serial_out_pin_ff,
  output reg           serial_out_oe_ff,
  output reg           serial_out_pullup_enable_ff,
  output reg           emb_page_ff,
  output reg           hub_page_enable_ff,
  input  wire          fifo_trigger,
  input  wire          accel_valid,
  input  wire [15:0]   accel_x,
  input  wire [15:0]   accel_y,
  input  wire          accel_rate_changed,
  input  wire          temp_valid,
  input  wire [15:0]   temp_data,
  input  wire [31:0]   tstamp,
  input  wire          accel_drdy_read,
  input  wire          temp_drdy_read,
  input  wire          status_read,
  input  wire          stamped_ready_flag,
  input  wire          boot_status,
  input  wire          embedded_route_one,
  input  wire          embedded_route_two,
  input  wire          irq_polarity_sel,
  input  wire          fifo_pop,
  output wire [55:0]   fifo_rd_data_ff,
  output reg           fifo_rd_valid_ff,
  output reg  [AW:0]   fifo_level_ff,
  output reg           watermark_flag_ff,
  output reg           fifo_full_ff,
  output reg           fifo_overrun_ff,
  output reg           batch_counter_hit_flag_ff,
  output reg           irq_pin_one_ff,
  output reg           irq_pin_two_ff
);

  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] sclk_sync_ff;
  reg [1:0] cs_sync_ff;
  reg [1:0] sdi_sync_ff;
  reg [1:0] trig_sync_ff;
  reg       sclk_last_ff;
  reg       trig_last_ff;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_sync_ff <= 2'b11;
      cs_sync_ff   <= 2'b11;
      sdi_sync_ff  <= 2'b00;
      trig_sync_ff <= 2'b00;
      sclk_last_ff <= 1'b1;
      trig_last_ff <= 1'b0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[0], serial_clk};
      cs_sync_ff   <= {cs_sync_ff[0], serial_cs_n};
      sdi_sync_ff  <= {sdi_sync_ff[0], serial_in};
      trig_sync_ff <= {trig_sync_ff[0], fifo_trigger};
      sclk_last_ff <= sclk_sync_ff[1];
      trig_last_ff <= trig_sync_ff[1];
    end
  end

  wire sclk_rise = sclk_sync_ff[1] & ~sclk_last_ff;
  wire sclk_fall = ~sclk_sync_ff[1] & sclk_last_ff;
  wire sel       = ~cs_sync_ff[1];
  wire trig_fall = ~trig_sync_ff[1] & trig_last_ff;

  ////////////////////////////////////////////////////////////////////////////
  // serial port: rw bit, 7-bit address, 8 data bits, msb first
  reg [3:0] bit_cnt_ff;
  reg [6:0] addr_ff;
  reg       rd_ff;
  reg [7:0] sh_in_ff;
  reg [7:0] sh_out_ff;
  reg       wr_stb_ff;
  reg [7:0] wr_data_ff;
  reg       load_ff;

  always @(posedge sys_clk) begin
    if (sys_rst || !sel) begin
      bit_cnt_ff <= 4'h0;
      addr_ff    <= 7'h00;
      rd_ff      <= 1'b0;
      sh_in_ff   <= 8'h00;
      wr_stb_ff  <= 1'b0;
      wr_data_ff <= 8'h00;
      load_ff    <= 1'b0;
    end else begin
      wr_stb_ff <= 1'b0;
      load_ff   <= 1'b0;
      if (sclk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        sh_in_ff   <= {sh_in_ff[6:0], sdi_sync_ff[1]};
        if (bit_cnt_ff == 4'h0) begin
          rd_ff <= sdi_sync_ff[1];
        end
        if (bit_cnt_ff == 4'h7) begin
          addr_ff <= {sh_in_ff[5:0], sdi_sync_ff[1]};
          load_ff <= 1'b1;
        end
        if (bit_cnt_ff == 4'hf && !rd_ff) begin
          wr_stb_ff  <= 1'b1;
          wr_data_ff <= {sh_in_ff[6:0], sdi_sync_ff[1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  reg [7:0] pg_ff;
  reg [7:0] pu_ff;
  reg [7:0] wtm_lo_ff;
  reg [7:0] wtm_hi_ff;
  reg [7:0] xl_rate_ff;
  reg [7:0] mode_ff;
  reg [7:0] bc_ctrl_ff;
  reg [7:0] bc_lo_ff;
  reg [7:0] rt1_ff;
  reg [7:0] rt2_ff;
  reg       bc_clear_ff;
  reg       mode_wr_ff;

  function wr_hit;
    input [6:0] a;
    begin
      wr_hit = wr_stb_ff && (addr_ff == a);
    end
  endfunction

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pg_ff       <= `SFB_RST_ZERO;
      pu_ff       <= `SFB_RST_PULLUP_CTRL;
      wtm_lo_ff   <= `SFB_RST_ZERO;
      wtm_hi_ff   <= `SFB_RST_ZERO;
      xl_rate_ff  <= `SFB_RST_ZERO;
      mode_ff     <= `SFB_RST_ZERO;
      bc_ctrl_ff  <= `SFB_RST_ZERO;
      bc_lo_ff    <= `SFB_RST_ZERO;
      rt1_ff      <= `SFB_RST_ZERO;
      rt2_ff      <= `SFB_RST_ZERO;
      bc_clear_ff <= 1'b0;
      mode_wr_ff  <= 1'b0;
    end else begin
      bc_clear_ff <= wr_hit(`SFB_ADDR_BCNT_CTRL) &&
                     wr_data_ff[`SFB_BIT_BCNT_CLEAR];
      mode_wr_ff  <= wr_hit(`SFB_ADDR_MODE_RATES);
      if (wr_hit(`SFB_ADDR_PAGE_SEL))
        pg_ff <= wr_data_ff & `SFB_MASK_PAGE_SEL;
      if (wr_hit(`SFB_ADDR_PULLUP_CTRL))
        pu_ff <= wr_data_ff;
      if (wr_hit(`SFB_ADDR_WTM_LOW))
        wtm_lo_ff <= wr_data_ff;
      if (wr_hit(`SFB_ADDR_WTM_HIGH_STOP))
        wtm_hi_ff <= wr_data_ff & `SFB_MASK_WTM_HIGH;
      if (wr_hit(`SFB_ADDR_ACCEL_RATE))
        xl_rate_ff <= wr_data_ff & `SFB_MASK_ACCEL_RATE;
      if (wr_hit(`SFB_ADDR_MODE_RATES))
        mode_ff <= wr_data_ff & `SFB_MASK_MODE_RATES;
      if (wr_hit(`SFB_ADDR_BCNT_CTRL))
        bc_ctrl_ff <= wr_data_ff & `SFB_MASK_BCNT_CTRL;
      if (wr_hit(`SFB_ADDR_BCNT_TH_LOW))
        bc_lo_ff <= wr_data_ff;
      if (wr_hit(`SFB_ADDR_IRQ1_ROUTE))
        rt1_ff <= wr_data_ff & `SFB_MASK_IRQ1_ROUTE;
      if (wr_hit(`SFB_ADDR_IRQ2_ROUTE))
        rt2_ff <= wr_data_ff & `SFB_MASK_IRQ2_ROUTE;
    end
  end

  // read mux; unmapped addresses read zero, clear bit always reads zero
  reg [7:0] rd_mux;
  always @* begin
    case (addr_ff)
      `SFB_ADDR_PAGE_SEL:      rd_mux = pg_ff;
      `SFB_ADDR_PULLUP_CTRL:   rd_mux = pu_ff;
      `SFB_ADDR_WTM_LOW:       rd_mux = wtm_lo_ff;
      `SFB_ADDR_WTM_HIGH_STOP: rd_mux = wtm_hi_ff;
      `SFB_ADDR_ACCEL_RATE:    rd_mux = xl_rate_ff;
      `SFB_ADDR_MODE_RATES:    rd_mux = mode_ff;
      `SFB_ADDR_BCNT_CTRL:     rd_mux = bc_ctrl_ff;
      `SFB_ADDR_BCNT_TH_LOW:   rd_mux = bc_lo_ff;
      `SFB_ADDR_IRQ1_ROUTE:    rd_mux = rt1_ff;
      `SFB_ADDR_IRQ2_ROUTE:    rd_mux = rt2_ff;
      default:                 rd_mux = 8'h00;
    endcase
  end

  // shift out on falling serial clock edges
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sh_out_ff         <= 8'h00;
      serial_out_pin_ff <= 1'b0;
      serial_out_oe_ff  <= 1'b0;
    end else if (!sel) begin
      serial_out_oe_ff <= 1'b0;
    end else if (load_ff && rd_ff) begin
      sh_out_ff        <= rd_mux;
      serial_out_oe_ff <= 1'b1;
    end else if (sclk_fall && serial_out_oe_ff) begin
      serial_out_pin_ff <= sh_out_ff[7];
      sh_out_ff         <= {sh_out_ff[6:0], 1'b0};
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_out_pullup_enable_ff <= 1'b0;
      emb_page_ff                 <= 1'b0;
      hub_page_enable_ff          <= 1'b0;
    end else begin
      serial_out_pullup_enable_ff <= pu_ff[`SFB_BIT_PULLUP_EN];
      emb_page_ff                 <= pg_ff[`SFB_BIT_EMB_PAGE];
      hub_page_enable_ff          <= pg_ff[`SFB_BIT_HUB_PAGE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode resolution; trigger switch latches until the mode is rewritten
  wire [8:0] watermark_threshold = {wtm_hi_ff[`SFB_BIT_WTM8], wtm_lo_ff};
  wire [2:0] mode_sel = mode_ff[2:0];
  reg        switched_ff;
  reg        eff_bypass;
  reg        eff_cont;

  always @(posedge sys_clk) begin
    if (sys_rst || mode_wr_ff)
      switched_ff <= 1'b0;
    else if (trig_fall)
      switched_ff <= 1'b1;
  end

  always @* begin
    eff_bypass = 1'b0;
    eff_cont   = 1'b0;
    case (mode_sel)
      `SFB_MODE_STOP_FULL:    eff_cont = 1'b0;
      `SFB_MODE_CONTINUOUS:   eff_cont = 1'b1;
      `SFB_MODE_CONT_TO_STOP: eff_cont = ~switched_ff;
      `SFB_MODE_BYP_TO_CONT: begin
        eff_bypass = ~switched_ff;
        eff_cont   = switched_ff;
      end
      `SFB_MODE_BYP_TO_STOP:  eff_bypass = ~switched_ff;
      default:                eff_bypass = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // batching: accel first, then pending rate-change, timestamp, temp
  wire       xl_batch = accel_valid && (xl_rate_ff[3:0] != 4'h0);
  reg        pend_chg_ff;
  reg        pend_ts_ff;
  reg        pend_t_ff;
  reg [4:0]  dec_cnt_ff;
  reg [4:0]  dec_max;
  reg        ts_due;

  always @* begin
    case (mode_ff[7:6])
      2'b01:   dec_max = 5'd0;
      2'b10:   dec_max = 5'd7;
      2'b11:   dec_max = 5'd31;
      default: dec_max = 5'd0;
    endcase
    ts_due = xl_batch && (mode_ff[7:6] != 2'b00) && (dec_cnt_ff == dec_max);
  end

  wire        do_chg = ~xl_batch & pend_chg_ff;
  wire        do_ts  = ~xl_batch & ~pend_chg_ff & pend_ts_ff;
  wire        do_t   = ~xl_batch & ~pend_chg_ff & ~pend_ts_ff & pend_t_ff;
  wire        push   = ~eff_bypass & (xl_batch | do_chg | do_ts | do_t);
  reg  [55:0] rec;

  always @* begin
    if (xl_batch)
      rec = {`SFB_TAG_ACCEL, accel_x, accel_y, 16'h0000};
    else if (do_chg)
      rec = {`SFB_TAG_RATE_CHG, 12'h000, xl_rate_ff[3:0], 32'h0000_0000};
    else if (do_ts)
      rec = {`SFB_TAG_TSTAMP, tstamp, 16'h0000};
    else
      rec = {`SFB_TAG_TEMP, temp_data, 32'h0000_0000};
  end

  always @(posedge sys_clk) begin
    if (sys_rst || eff_bypass) begin
      pend_chg_ff <= 1'b0;
      pend_ts_ff  <= 1'b0;
      pend_t_ff   <= 1'b0;
      dec_cnt_ff  <= 5'd0;
    end else begin
      if (accel_rate_changed && wtm_hi_ff[`SFB_BIT_RATE_CHG_EN])
        pend_chg_ff <= 1'b1;
      else if (do_chg)
        pend_chg_ff <= 1'b0;
      if (ts_due)
        pend_ts_ff <= 1'b1;
      else if (do_ts)
        pend_ts_ff <= 1'b0;
      if (temp_valid && (mode_ff[5:4] != 2'b00))
        pend_t_ff <= 1'b1;
      else if (do_t)
        pend_t_ff <= 1'b0;
      if (xl_batch)
        dec_cnt_ff <= (dec_cnt_ff >= dec_max) ? 5'd0 : dec_cnt_ff + 5'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo pointers and flags
  reg  [AW-1:0] wr_ptr_ff;
  reg  [AW-1:0] rd_ptr_ff;
  wire [AW:0]   cap = wtm_hi_ff[`SFB_BIT_STOP_AT_TH] ?
                      {{(AW-8){1'b0}}, watermark_threshold} : DEPTH;
  wire          full = (fifo_level_ff >= cap);
  wire          wr_ok = push & (~full | eff_cont);
  wire          ovw   = push & full & eff_cont;
  wire          rd_ok = fifo_pop & (fifo_level_ff != 0) & ~ovw;
  wire [AW-1:0] rd_addr = rd_ptr_ff;

  sfb_mem #(.WIDTH(56), .AW(AW)) u_mem (
    .sys_clk    (sys_clk),
    .wr_en      (wr_ok),
    .wr_addr    (wr_ptr_ff),
    .wr_data    (rec),
    .rd_addr    (rd_addr),
    .rd_data_ff (fifo_rd_data_ff)
  );

  always @(posedge sys_clk) begin
    if (sys_rst || eff_bypass) begin
      wr_ptr_ff        <= {AW{1'b0}};
      rd_ptr_ff        <= {AW{1'b0}};
      fifo_level_ff    <= {(AW+1){1'b0}};
      fifo_rd_valid_ff <= 1'b0;
    end else begin
      fifo_rd_valid_ff <= rd_ok;
      if (wr_ok)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (rd_ok || ovw)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (wr_ok && !ovw && !rd_ok)
        fifo_level_ff <= fifo_level_ff + 1'b1;
      else if (rd_ok && !wr_ok)
        fifo_level_ff <= fifo_level_ff - 1'b1;
    end
  end

  // overrun sticky until status read; a new event beats the clear
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      watermark_flag_ff <= 1'b0;
      fifo_full_ff      <= 1'b0;
      fifo_overrun_ff   <= 1'b0;
    end else begin
      watermark_flag_ff <= (fifo_level_ff >=
                            {{(AW-8){1'b0}}, watermark_threshold});
      fifo_full_ff      <= full;
      if (push && full)
        fifo_overrun_ff <= 1'b1;
      else if (status_read)
        fifo_overrun_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // batch-event counter on accel batches
  wire [10:0] batch_counter_threshold = {bc_ctrl_ff[2:0], bc_lo_ff};
  reg  [10:0] bcnt_ff;
  wire        bc_evt = xl_batch & ~eff_bypass;
  wire        bc_hit = bc_evt &&
                       (bcnt_ff + 11'd1 == batch_counter_threshold);

  always @(posedge sys_clk) begin
    if (sys_rst || bc_clear_ff) begin
      bcnt_ff <= 11'd0;
    end else if (bc_hit) begin
      bcnt_ff <= 11'd0;
    end else if (bc_evt) begin
      bcnt_ff <= bcnt_ff + 11'd1;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst)
      batch_counter_hit_flag_ff <= 1'b0;
    else if (bc_hit)
      batch_counter_hit_flag_ff <= 1'b1;
    else if (status_read)
      batch_counter_hit_flag_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data-ready: latched until read, or fixed-length pulse
  localparam PW = 16;
  reg [PW-1:0] xl_pcnt_ff;
  reg [PW-1:0] t_pcnt_ff;
  reg          xl_lat_ff;
  reg          t_lat_ff;
  wire         pulsed = bc_ctrl_ff[`SFB_BIT_PULSED];

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      xl_lat_ff  <= 1'b0;
      t_lat_ff   <= 1'b0;
      xl_pcnt_ff <= {PW{1'b0}};
      t_pcnt_ff  <= {PW{1'b0}};
    end else begin
      if (accel_valid)
        xl_lat_ff <= 1'b1;
      else if (accel_drdy_read)
        xl_lat_ff <= 1'b0;
      if (temp_valid)
        t_lat_ff <= 1'b1;
      else if (temp_drdy_read)
        t_lat_ff <= 1'b0;
      if (accel_valid)
        xl_pcnt_ff <= PULSE_CYC[PW-1:0];
      else if (xl_pcnt_ff != 0)
        xl_pcnt_ff <= xl_pcnt_ff - 1'b1;
      if (temp_valid)
        t_pcnt_ff <= PULSE_CYC[PW-1:0];
      else if (t_pcnt_ff != 0)
        t_pcnt_ff <= t_pcnt_ff - 1'b1;
    end
  end

  wire xl_drdy = pulsed ? (xl_pcnt_ff != 0) : xl_lat_ff;
  wire t_drdy  = pulsed ? (t_pcnt_ff != 0) : t_lat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pins
  wire [7:0] src1 = {stamped_ready_flag, batch_counter_hit_flag_ff,
                     fifo_full_ff, fifo_overrun_ff, watermark_flag_ff,
                     boot_status, 1'b0, xl_drdy};
  wire [7:0] src2 = {1'b0, batch_counter_hit_flag_ff, fifo_full_ff,
                     fifo_overrun_ff, watermark_flag_ff, t_drdy,
                     1'b0, xl_drdy};
  wire irq1 = |(src1 & rt1_ff) | embedded_route_one;
  wire irq2 = |(src2 & rt2_ff) | embedded_route_two;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_pin_one_ff <= 1'b0;
      irq_pin_two_ff <= 1'b0;
    end else begin
      irq_pin_one_ff <= irq1 ^ irq_polarity_sel;
      irq_pin_two_ff <= irq2 ^ irq_polarity_sel;
    end
  end

endmodule // sfb_top

// ---- sfb_host_model.sv ----
// sfb_host_model.sv: serial host on the register port, clock idles high
// assumes: 64 ns link clock, one register byte per select frame
`timescale 1ns/1ps
module sfb_host_model (
  output logic serial_clk,
  output logic serial_cs_n,
  output logic serial_in,
  input  wire  serial_out_pin_ff,
  input  wire  serial_out_oe_ff,
  input  wire  serial_out_pullup_enable_ff
);
  logic [15:0] frm;
  // released line sits on the pull-up, else shows the inverse of the pin
  wire serial_out_pin = serial_out_oe_ff ? serial_out_pin_ff :
             serial_out_pullup_enable_ff ? 1'b1 : ~serial_out_pin_ff;

  initial begin
    serial_clk = 1'b1;
    serial_cs_n = 1'b1;
    serial_in = 1'b0;
  end

  ////////////////////////////////////////
  task automatic xfer(input logic rw, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    frm = {rw, a, d};
    serial_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #32 serial_clk = 1'b0;
      serial_in = frm[i];
      #32 serial_clk = 1'b1;
      q = {q[6:0], serial_out_pin};
    end
    #32 serial_cs_n = 1'b1;
    // released data line must not look like held data
    serial_in = ~serial_in;
    #100;
  endtask
endmodule // sfb_host_model

// ---- sfb_monitor.sv ----
// sfb_monitor.sv: port checks on sfb_top
// assumes: single sys_clk domain, bound below
`timescale 1ns/1ps
module sfb_monitor #(
  parameter AW = 9
) (
  input logic        sys_clk,
  input logic        sys_rst,
  input logic        serial_cs_n,
  input logic        serial_out_oe_ff,
  input logic        accel_valid,
  input logic        fifo_pop,
  input logic        status_read,
  input logic        embedded_route_one,
  input logic        embedded_route_two,
  input logic        irq_polarity_sel,
  input logic        fifo_rd_valid_ff,
  input logic [AW:0] fifo_level_ff,
  input logic        batch_counter_hit_flag_ff,
  input logic        irq_pin_one_ff,
  input logic        irq_pin_two_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // deselect passes a 2-flop sync first
  property p_oe_idle;
    serial_cs_n [*8] |-> !serial_out_oe_ff;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("serial out driven while deselected");
  property p_lvl_step;
    $changed(fifo_level_ff) |-> fifo_level_ff == '0 ||
      fifo_level_ff == $past(fifo_level_ff) + 1'b1 ||
      fifo_level_ff == $past(fifo_level_ff) - 1'b1;
  endproperty
  a_lvl_step: assert property (p_lvl_step)
    else $error("fill level jumped");
  property p_lvl_pop;
    fifo_level_ff == $past(fifo_level_ff) - 1'b1 && fifo_level_ff != '0
      |-> $past(fifo_pop);
  endproperty
  a_lvl_pop: assert property (p_lvl_pop)
    else $error("fill level fell without a pop");
  property p_pop_rsp;
    fifo_pop && fifo_level_ff != '0 && !accel_valid |=> fifo_rd_valid_ff;
  endproperty
  a_pop_rsp: assert property (p_pop_rsp)
    else $error("pop not answered");
  property p_rsp_cause;
    fifo_rd_valid_ff |-> $past(fifo_pop) && $past(fifo_level_ff) != '0;
  endproperty
  a_rsp_cause: assert property (p_rsp_cause)
    else $error("record out without pop");
  property p_irq_one;
    (embedded_route_one && !irq_polarity_sel) [*3] |-> irq_pin_one_ff;
  endproperty
  a_irq_one: assert property (p_irq_one)
    else $error("pin one missed embedded source");
  property p_irq_two;
    (embedded_route_two && irq_polarity_sel) [*3] |-> !irq_pin_two_ff;
  endproperty
  a_irq_two: assert property (p_irq_two)
    else $error("pin two polarity wrong");
  property p_hit_clr;
    $fell(batch_counter_hit_flag_ff) |-> $past(status_read);
  endproperty
  a_hit_clr: assert property (p_hit_clr)
    else $error("counter flag dropped without status read");
endmodule // sfb_monitor

bind sfb_top sfb_monitor #(.AW(AW)) u_mon (
  .sys_clk, .sys_rst, .serial_cs_n, .serial_out_oe_ff, .accel_valid,
  .fifo_pop, .status_read, .embedded_route_one, .embedded_route_two,
  .irq_polarity_sel, .fifo_rd_valid_ff, .fifo_level_ff,
  .batch_counter_hit_flag_ff, .irq_pin_one_ff, .irq_pin_two_ff
);

// ---- sfb_top_tb.sv ----
// sfb_top_tb.sv: register, fifo and irq sequences for sfb_top
// assumes: sfb_host_model drives the serial pins, short pulse count
`timescale 1ns/1ps
`include "sfb_defs.vh"
module sfb_top_tb;
  logic        sys_clk = 0;
  logic        sys_rst = 1;
  logic        fifo_trigger = 0;
  logic [6:0]  st = 0;
  logic [15:0] accel_x = 16'h1234;
  logic [15:0] accel_y = 16'h5678;
  logic [15:0] temp_data = 16'h0abc;
  logic [31:0] tstamp = 0;
  logic        stamped_ready_flag = 0;
  logic        boot_status = 0;
  logic        embedded_route_one = 0;
  logic        embedded_route_two = 0;
  logic        irq_polarity_sel = 0;
  wire         accel_valid, accel_rate_changed, temp_valid, fifo_pop;
  wire         status_read, accel_drdy_read, temp_drdy_read;
  wire         serial_clk, serial_cs_n, serial_in, serial_out_pin_ff;
  wire         serial_out_oe_ff, serial_out_pullup_enable_ff;
  wire         emb_page_ff, hub_page_enable_ff, fifo_rd_valid_ff;
  wire [55:0]  fifo_rd_data_ff;
  wire [9:0]   fifo_level_ff;
  wire         watermark_flag_ff, fifo_full_ff, fifo_overrun_ff;
  wire         batch_counter_hit_flag_ff, irq_pin_one_ff, irq_pin_two_ff;
  int          bad_count = 0;
  int          comparisons = 0;
  logic [7:0]  q;
  logic [6:0]  ra [11] = '{7'h01, 7'h02, 7'h07, 7'h08, 7'h09, 7'h0a,
                           7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h03};
  logic [7:0]  mk [11] = '{8'hc0, 8'hff, 8'hff, 8'h91, 8'h0f, 8'hf7,
                           8'h87, 8'hff, 8'hfd, 8'h7d, 8'h00};
  logic [7:0]  tg [4] = '{8'h02, 8'h01, 8'h03, 8'h04};

  assign {temp_drdy_read, accel_drdy_read, status_read, fifo_pop,
          temp_valid, accel_rate_changed, accel_valid} = st;

  sfb_top #(.PULSE_CYC(20)) DUT (.*);
  sfb_host_model h (.serial_clk, .serial_cs_n, .serial_in,
    .serial_out_pin_ff, .serial_out_oe_ff, .serial_out_pullup_enable_ff);

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) tstamp <= tstamp + 1;

  ////////////////////////////////////////
  task chk(input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task p(input int k);
    @(posedge sys_clk) st <= 7'h01 << k;
    @(posedge sys_clk) st <= 7'h00;
  endtask
  task w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    h.xfer(1'b0, a, d, q);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    h.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask
  task pop;
    p(3);
    #1;
  endtask
  task print_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // generous: sixty-four frames plus a full fifo fill
  initial begin
    #200_000;
    bad_count++;
    print_verdict;
  end

  ////////////////////////////////////////
  initial begin
    w(20);
    sys_rst <= 1'b0;
    w(4);
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], i == 1 ? 8'h3f : 8'h00);
    end
    for (int i = 0; i < 11; i++) begin
      wr(ra[i], 8'hff);
      rd(ra[i], mk[i]);
    end
    chk(serial_out_pullup_enable_ff, 1);
    chk({emb_page_ff, hub_page_enable_ff}, 2'b11);
    for (int i = 0; i < 10; i++) begin
      wr(ra[i], i == 1 ? 8'h3f : 8'h00);
    end
    chk(serial_out_pullup_enable_ff, 0);
    wr(7'h07, 8'h03);
    wr(7'h08, 8'h80);
    wr(7'h09, 8'h01);
    wr(7'h0d, 8'h10);
    wr(7'h0e, 8'h08);
    wr(7'h0a, 8'h01);
    repeat (4) p(0);
    w(3);
    chk(fifo_level_ff, 3);
    chk(watermark_flag_ff, 1);
    chk(fifo_overrun_ff, 1);
    chk({irq_pin_one_ff, irq_pin_two_ff}, 2'b11);
    pop;
    chk(fifo_rd_data_ff, 56'h01_1234_5678_0000);
    w(3);
    chk({watermark_flag_ff, irq_pin_two_ff}, 0);
    p(4);
    w(2);
    chk({fifo_overrun_ff, irq_pin_one_ff}, 0);
    wr(7'h0a, 8'h00);
    chk(fifo_level_ff, 0);
    wr(7'h08, 8'h10);
    wr(7'h0a, 8'h51);
    p(2);
    p(0);
    w(4);
    p(1);
    w(4);
    chk(fifo_level_ff, 4);
    for (int i = 0; i < 4; i++) begin
      pop;
      chk(fifo_rd_data_ff[55:48], tg[i]);
    end
    wr(7'h09, 8'h00);
    p(0);
    w(3);
    chk(fifo_level_ff, 0);
    wr(7'h09, 8'h01);
    wr(7'h0a, 8'h06);
    for (int i = 0; i < 513; i++) begin
      accel_x <= 16'(i);
      p(0);
    end
    w(3);
    chk({fifo_full_ff, fifo_level_ff}, 11'h600);
    pop;
    chk(fifo_rd_data_ff[47:32], 16'h0001);
    wr(7'h0a, 8'h00);
    @(posedge sys_clk) fifo_trigger <= 1'b1;
    wr(7'h0a, 8'h04);
    p(0);
    w(3);
    chk(fifo_level_ff, 0);
    @(posedge sys_clk) fifo_trigger <= 1'b0;
    w(6);
    p(0);
    w(3);
    chk(fifo_level_ff, 1);
    wr(7'h0a, 8'h00);
    wr(7'h0c, 8'h02);
    wr(7'h0b, 8'h40);
    rd(7'h0b, 8'h00);
    p(4);
    wr(7'h0a, 8'h01);
    p(0);
    w(3);
    chk(batch_counter_hit_flag_ff, 0);
    p(0);
    w(3);
    chk(batch_counter_hit_flag_ff, 1);
    p(4);
    wr(7'h0d, 8'h85);
    chk(irq_pin_one_ff, 1);
    p(5);
    w(2);
    chk(irq_pin_one_ff, 0);
    wr(7'h0b, 8'h80);
    p(0);
    w(3);
    chk(irq_pin_one_ff, 1);
    w(25);
    chk(irq_pin_one_ff, 0);
    @(posedge sys_clk) boot_status <= 1'b1;
    w(3);
    chk(irq_pin_one_ff, 1);
    @(posedge sys_clk) {boot_status, stamped_ready_flag} <= 2'b01;
    w(3);
    chk(irq_pin_one_ff, 1);
    @(posedge sys_clk) embedded_route_one <= 1'b1;
    stamped_ready_flag <= 1'b0;
    w(4);
    chk(irq_pin_one_ff, 1);
    @(posedge sys_clk) irq_polarity_sel <= 1'b1;
    embedded_route_two <= 1'b1;
    w(4);
    chk({irq_pin_one_ff, irq_pin_two_ff}, 0);
    p(5);
    p(6);
    print_verdict;
  end
endmodule // sfb_top_tb
